// ---- src/reset_cause_pkg.sv ----
// shared offsets, field positions, reset values and carrier types
package reset_cause_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] OFF_RESET_CAUSE_ONE = 8'h08;
  localparam logic [7:0] OFF_RESET_CAUSE_TWO = 8'h09;
  localparam logic [7:0] OFF_POWER_MONITOR_IRQ_MASK = 8'h0b;
  localparam logic [7:0] OFF_POWER_SOURCE_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_RESET_CAUSE_ONE_MASK = 8'h11;
  localparam logic [7:0] OFF_RESET_CAUSE_TWO_MASK = 8'h12;

  localparam logic [7:0] RST_RESET_CAUSE_ONE = 8'h00;
  localparam logic [7:0] RST_RESET_CAUSE_TWO = 8'h00;
  localparam logic [7:0] RST_POWER_MONITOR_IRQ_MASK = 8'h14;
  localparam logic [7:0] RST_POWER_SOURCE_IRQ_MASK = 8'h78;
  localparam logic [7:0] RST_RESET_CAUSE_ONE_MASK = 8'h30;
  localparam logic [7:0] RST_RESET_CAUSE_TWO_MASK = 8'h02;

  // field positions
  localparam int unsigned BIT_BUTTON_FORCED = 5;
  localparam int unsigned BIT_REGULATOR_FAULT = 4;
  localparam int unsigned BIT_CRITICAL_HEAT = 1;
  localparam int unsigned BIT_ADAPTER_SUPPLY = 4;
  localparam int unsigned BIT_CRITICAL_SUPPLY = 2;
  localparam int unsigned BIT_SECOND_CELL_LOW = 6;
  localparam int unsigned BIT_FIRST_CELL_LOW = 5;
  localparam int unsigned BIT_ADAPTER_DETECT = 4;
  localparam int unsigned BIT_CHIP_HOT = 3;

  // writable bits per register; all others reserved
  localparam logic [7:0] WMASK_RESET_CAUSE_ONE = 8'h30;
  localparam logic [7:0] WMASK_RESET_CAUSE_TWO = 8'h02;
  localparam logic [7:0] WMASK_POWER_MONITOR = 8'h14;
  localparam logic [7:0] WMASK_POWER_SOURCE = 8'h78;

  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CAUSE_COUNT = 3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic button_forced;
    logic regulator_fault;
    logic critical_heat;
  } reset_cause_t;

  typedef struct packed {
    logic adapter_supply;
    logic critical_supply;
  } pmu_pend_t;

  typedef struct packed {
    logic second_cell_low;
    logic first_cell_low;
    logic adapter_detect;
    logic chip_hot;
  } pwrsrc_pend_t;

  typedef struct packed {
    logic reset_sum;
    logic pmu_sum;
    logic pwrsrc_sum;
  } irq_sum_t;
endpackage : reset_cause_pkg

// ---- src/level_sync.sv ----
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module level_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // elaboration check: an empty vector has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("level_sync width must be at least one");
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        meta_r[g] <= 1'b0;
        sync_r[g] <= 1'b0;
      end else begin
        meta_r[g] <= i_async[g];
        sync_r[g] <= meta_r[g];
      end
    end
  end

  assign o_sync = sync_r;
endmodule : level_sync

// ---- src/reset_cause_irq_mask_regs.sv ----
// emergency reset cause flags and interrupt mask registers
`timescale 1ns/1ns
// What this block does
// - button hold reset sets cause one bit 5
// - regulator fault reset sets cause one bit 4
// - critical heat shutdown sets cause two bit 1
// - button reset mask, bit 5, resets masked
// - regulator fault mask, bit 4, resets masked
// - critical heat mask, bit 1, resets masked
// - adapter supply mask, monitor bit 4
// - critical supply mask, monitor bit 2
// - cell low masks, source bits 6, 5
// - adapter detect mask, source bit 4
// - chip hot mask, source bit 3
module reset_cause_irq_mask_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire reset_cause_pkg::reg_req_t i_req,
  input wire reset_cause_pkg::reset_cause_t i_cause,
  input wire reset_cause_pkg::pmu_pend_t i_pmu_pend,
  input wire reset_cause_pkg::pwrsrc_pend_t i_pwrsrc_pend,
  output logic [reset_cause_pkg::DATA_W-1:0] o_rd_data,
  output reset_cause_pkg::irq_sum_t o_irq_sum,
  output logic o_irq
);
  import reset_cause_pkg::*;

  reset_cause_t cause_s;
  logic [7:0] cause_one_r, cause_one_nxt;
  logic [7:0] cause_two_r, cause_two_nxt;
  logic [7:0] pmu_mask_r, pmu_mask_nxt;
  logic [7:0] src_mask_r, src_mask_nxt;
  logic [7:0] one_mask_r, one_mask_nxt;
  logic [7:0] two_mask_r, two_mask_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  irq_sum_t sum_r, sum_nxt;
  logic [7:0] pmu_pend_v;
  logic [7:0] src_pend_v;

  level_sync #(
    .WIDTH(CAUSE_COUNT)
  ) u_cause_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_cause),
    .o_sync(cause_s)
  );

  always_comb begin
    pmu_pend_v = 8'h00;
    pmu_pend_v[BIT_ADAPTER_SUPPLY] = i_pmu_pend.adapter_supply;
    pmu_pend_v[BIT_CRITICAL_SUPPLY] = i_pmu_pend.critical_supply;
    src_pend_v = 8'h00;
    src_pend_v[BIT_SECOND_CELL_LOW] = i_pwrsrc_pend.second_cell_low;
    src_pend_v[BIT_FIRST_CELL_LOW] = i_pwrsrc_pend.first_cell_low;
    src_pend_v[BIT_ADAPTER_DETECT] = i_pwrsrc_pend.adapter_detect;
    src_pend_v[BIT_CHIP_HOT] = i_pwrsrc_pend.chip_hot;
  end

  // register writes; hardware set wins over a software clear
  always_comb begin
    cause_one_nxt = cause_one_r;
    cause_two_nxt = cause_two_r;
    pmu_mask_nxt = pmu_mask_r;
    src_mask_nxt = src_mask_r;
    one_mask_nxt = one_mask_r;
    two_mask_nxt = two_mask_r;
    if (i_req.wr) begin
      case (i_req.addr)
        OFF_RESET_CAUSE_ONE: begin
          cause_one_nxt = i_req.wdata & WMASK_RESET_CAUSE_ONE;
        end
        OFF_RESET_CAUSE_TWO: begin
          cause_two_nxt = i_req.wdata & WMASK_RESET_CAUSE_TWO;
        end
        OFF_POWER_MONITOR_IRQ_MASK: begin
          pmu_mask_nxt = i_req.wdata & WMASK_POWER_MONITOR;
        end
        OFF_POWER_SOURCE_IRQ_MASK: begin
          src_mask_nxt = i_req.wdata & WMASK_POWER_SOURCE;
        end
        OFF_RESET_CAUSE_ONE_MASK: begin
          one_mask_nxt = i_req.wdata & WMASK_RESET_CAUSE_ONE;
        end
        OFF_RESET_CAUSE_TWO_MASK: begin
          two_mask_nxt = i_req.wdata & WMASK_RESET_CAUSE_TWO;
        end
        default: begin
          cause_one_nxt = cause_one_r;
        end
      endcase
    end
    if (cause_s.button_forced) begin
      cause_one_nxt[BIT_BUTTON_FORCED] = 1'b1;
    end
    if (cause_s.regulator_fault) begin
      cause_one_nxt[BIT_REGULATOR_FAULT] = 1'b1;
    end
    if (cause_s.critical_heat) begin
      cause_two_nxt[BIT_CRITICAL_HEAT] = 1'b1;
    end
  end

  // read data and masked summaries
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (i_req.rd) begin
      case (i_req.addr)
        OFF_RESET_CAUSE_ONE: rd_data_nxt = cause_one_r;
        OFF_RESET_CAUSE_TWO: rd_data_nxt = cause_two_r;
        OFF_POWER_MONITOR_IRQ_MASK: rd_data_nxt = pmu_mask_r;
        OFF_POWER_SOURCE_IRQ_MASK: rd_data_nxt = src_mask_r;
        OFF_RESET_CAUSE_ONE_MASK: rd_data_nxt = one_mask_r;
        OFF_RESET_CAUSE_TWO_MASK: rd_data_nxt = two_mask_r;
        default: rd_data_nxt = 8'h00;
      endcase
    end
    sum_nxt.reset_sum = |(cause_one_r & ~one_mask_r) | |(cause_two_r & ~two_mask_r);
    sum_nxt.pmu_sum = |(pmu_pend_v & ~pmu_mask_r);
    sum_nxt.pwrsrc_sum = |(src_pend_v & ~src_mask_r);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_one_r <= RST_RESET_CAUSE_ONE;
      cause_two_r <= RST_RESET_CAUSE_TWO;
      pmu_mask_r <= RST_POWER_MONITOR_IRQ_MASK;
      src_mask_r <= RST_POWER_SOURCE_IRQ_MASK;
      one_mask_r <= RST_RESET_CAUSE_ONE_MASK;
      two_mask_r <= RST_RESET_CAUSE_TWO_MASK;
      rd_data_r <= 8'h00;
      sum_r <= '0;
    end else begin
      cause_one_r <= cause_one_nxt;
      cause_two_r <= cause_two_nxt;
      pmu_mask_r <= pmu_mask_nxt;
      src_mask_r <= src_mask_nxt;
      one_mask_r <= one_mask_nxt;
      two_mask_r <= two_mask_nxt;
      rd_data_r <= rd_data_nxt;
      sum_r <= sum_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_irq_sum = sum_r;
  assign o_irq = |sum_r;

  AST_BUTTON_SET: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    cause_s.button_forced |=> cause_one_r[BIT_BUTTON_FORCED])
    else $error("button forced flag not set");

  AST_REGULATOR_SET: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    cause_s.regulator_fault |=> cause_one_r[BIT_REGULATOR_FAULT])
    else $error("regulator fault flag not set");

  AST_HEAT_SET: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    cause_s.critical_heat |=> cause_two_r[BIT_CRITICAL_HEAT])
    else $error("critical heat flag not set");

  AST_HEAT_HOLD: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !cause_two_r[BIT_CRITICAL_HEAT] && !cause_s.critical_heat &&
      !(i_req.wr && i_req.addr == OFF_RESET_CAUSE_TWO) |=> !cause_two_r[BIT_CRITICAL_HEAT])
    else $error("critical heat flag rose without cause");

  AST_ONE_MASK_WR: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == OFF_RESET_CAUSE_ONE_MASK |=>
      one_mask_r == ($past(i_req.wdata) & WMASK_RESET_CAUSE_ONE))
    else $error("cause one mask write lost");

  AST_ONE_MASK_GATE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (one_mask_r[BIT_REGULATOR_FAULT] && one_mask_r[BIT_BUTTON_FORCED] &&
      (cause_two_r & ~two_mask_r) == 8'h00) |=> !o_irq_sum.reset_sum)
    else $error("masked cause reached summary");

  AST_TWO_MASK_WR: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == OFF_RESET_CAUSE_TWO_MASK ##1 i_req.rd &&
      i_req.addr == OFF_RESET_CAUSE_TWO_MASK |=>
      o_rd_data == ($past(i_req.wdata, 2) & WMASK_RESET_CAUSE_TWO))
    else $error("cause two mask readback wrong");

  AST_PMU_GATE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_pmu_pend.adapter_supply && !pmu_mask_r[BIT_ADAPTER_SUPPLY] |=> o_irq_sum.pmu_sum)
    else $error("open adapter supply cause missed");

  AST_PMU_QUIET: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!i_pmu_pend.adapter_supply || pmu_mask_r[BIT_ADAPTER_SUPPLY]) &&
      (!i_pmu_pend.critical_supply || pmu_mask_r[BIT_CRITICAL_SUPPLY]) |=> !o_irq_sum.pmu_sum)
    else $error("masked monitor cause reached summary");

  AST_PMU_RSVD: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (pmu_mask_r & ~WMASK_POWER_MONITOR) == 8'h00)
    else $error("monitor mask reserved bit set");

  AST_SRC_GATE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_pwrsrc_pend.second_cell_low && !src_mask_r[BIT_SECOND_CELL_LOW]) ||
      (i_pwrsrc_pend.first_cell_low && !src_mask_r[BIT_FIRST_CELL_LOW]) ||
      (i_pwrsrc_pend.adapter_detect && !src_mask_r[BIT_ADAPTER_DETECT]) ||
      (i_pwrsrc_pend.chip_hot && !src_mask_r[BIT_CHIP_HOT]) |=> o_irq_sum.pwrsrc_sum)
    else $error("open source cause missed");

  AST_SRC_QUIET: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_pwrsrc_pend & ~{src_mask_r[BIT_SECOND_CELL_LOW], src_mask_r[BIT_FIRST_CELL_LOW],
      src_mask_r[BIT_ADAPTER_DETECT], src_mask_r[BIT_CHIP_HOT]}) == 4'h0 |=>
      !o_irq_sum.pwrsrc_sum)
    else $error("masked source cause reached summary");

  AST_SRC_WR: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == OFF_POWER_SOURCE_IRQ_MASK |=>
      src_mask_r == ($past(i_req.wdata) & WMASK_POWER_SOURCE))
    else $error("source mask write lost");

  AST_SRC_HOLD: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !(i_req.wr && i_req.addr == OFF_POWER_SOURCE_IRQ_MASK) |=> $stable(src_mask_r))
    else $error("source mask changed without write");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == 8'h0a |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule : reset_cause_irq_mask_regs

// ---- tb/ec_host_model.sv ----
// host model issuing register writes and reads on the strobe port
`timescale 1ns/1ns
module ec_host_model (
  input wire logic i_clk_sys,
  input wire logic [reset_cause_pkg::DATA_W-1:0] i_rd_data,
  output reset_cause_pkg::reg_req_t o_req
);
  import reset_cause_pkg::*;

  initial begin
    o_req = '0;
  end

  // released address and data show the inverse of the last value
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : wr_reg

  // write then read of one register in back-to-back cycles
  task automatic wr_rd_reg(input logic [7:0] addr, input logic [7:0] data,
    output logic [7:0] rdata);
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~data};
    @(posedge i_clk_sys);
    #1;
    rdata = i_rd_data;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: data};
  endtask : wr_rd_reg

  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'ha5};
    @(posedge i_clk_sys);
    #1;
    data = i_rd_data;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'h5a};
  endtask : rd_reg
endmodule : ec_host_model

// ---- tb/reset_cause_irq_mask_regs_test.sv ----
// self-checking bench for the reset cause flags and interrupt masks
`timescale 1ns/1ns
module reset_cause_irq_mask_regs_test;
  import reset_cause_pkg::*;

  logic i_clk_sys;
  logic i_rst_n;
  reg_req_t req;
  reset_cause_t i_cause;
  pmu_pend_t i_pmu_pend;
  pwrsrc_pend_t i_pwrsrc_pend;
  logic [7:0] o_rd_data;
  irq_sum_t o_irq_sum;
  logic o_irq;
  int error_cnt = 0;
  int comparisons = 0;
  logic [7:0] offs [6] = '{OFF_RESET_CAUSE_ONE, OFF_RESET_CAUSE_TWO, OFF_POWER_MONITOR_IRQ_MASK,
    OFF_POWER_SOURCE_IRQ_MASK, OFF_RESET_CAUSE_ONE_MASK, OFF_RESET_CAUSE_TWO_MASK};
  logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h14, 8'h78, 8'h30, 8'h02};
  logic [7:0] wms [6] = '{8'h30, 8'h02, 8'h14, 8'h78, 8'h30, 8'h02};

  reset_cause_irq_mask_regs reset_cause_irq_mask_regs_inst (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_req(req), .i_cause(i_cause), .i_pmu_pend(i_pmu_pend),
    .i_pwrsrc_pend(i_pwrsrc_pend), .o_rd_data(o_rd_data), .o_irq_sum(o_irq_sum), .o_irq(o_irq));
  ec_host_model ec_host_model_inst (.i_clk_sys(i_clk_sys), .i_rd_data(o_rd_data), .o_req(req));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    ec_host_model_inst.rd_reg(addr, d);
    chk($sformatf("reg %h", addr), d, exp);
  endtask : rd_chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : wait_clk

  task automatic t_reset_values();
    for (int i = 0; i < 6; i++) rd_chk(offs[i], rsts[i]);
    rd_chk(8'h0a, 8'h00);
  endtask : t_reset_values

  task automatic t_write_read();
    ec_host_model_inst.wr_reg(8'h13, 8'hff);
    for (int i = 0; i < 6; i++) begin
      ec_host_model_inst.wr_reg(offs[i], 8'hff);
      rd_chk(offs[i], wms[i]);
      ec_host_model_inst.wr_reg(offs[i], 8'h00);
      rd_chk(offs[i], 8'h00);
    end
  endtask : t_write_read

  // masks all open here: every cause must reach the interrupt line
  task automatic t_causes();
    reset_cause_t cv [3] = '{3'b100, 3'b010, 3'b001};
    logic [7:0] ro [3] = '{OFF_RESET_CAUSE_ONE, OFF_RESET_CAUSE_ONE, OFF_RESET_CAUSE_TWO};
    logic [7:0] rv [3] = '{8'h20, 8'h10, 8'h02};
    for (int i = 0; i < 3; i++) begin
      i_cause = cv[i];
      wait_clk(5);
      i_cause = '0;
      rd_chk(ro[i], rv[i]);
      chk("irq", {7'h00, o_irq}, 8'h01);
      chk("reset_sum", {7'h00, o_irq_sum.reset_sum}, 8'h01);
      ec_host_model_inst.wr_reg(ro[i], 8'h00);
      wait_clk(2);
      rd_chk(ro[i], 8'h00);
      chk("irq clear", {7'h00, o_irq}, 8'h00);
    end
    ec_host_model_inst.wr_reg(OFF_RESET_CAUSE_ONE_MASK, 8'h30);
    i_cause = 3'b100;
    wait_clk(6);
    chk("masked irq", {7'h00, o_irq}, 8'h00);
    ec_host_model_inst.wr_reg(OFF_RESET_CAUSE_ONE_MASK, 8'h10);
    wait_clk(2);
    chk("unmasked irq", {7'h00, o_irq}, 8'h01);
    i_cause = '0;
    ec_host_model_inst.wr_reg(OFF_RESET_CAUSE_ONE_MASK, 8'h20);
    wait_clk(2);
    chk("other masked", {7'h00, o_irq}, 8'h00);
    ec_host_model_inst.wr_reg(OFF_RESET_CAUSE_ONE, 8'h00);
  endtask : t_causes

  task automatic t_pending();
    i_pmu_pend = 2'b10;
    ec_host_model_inst.wr_reg(OFF_POWER_MONITOR_IRQ_MASK, 8'h10);
    wait_clk(2);
    chk("pmu masked", {7'h00, o_irq_sum.pmu_sum}, 8'h00);
    i_pmu_pend = 2'b01;
    wait_clk(2);
    chk("pmu open", {7'h00, o_irq_sum.pmu_sum}, 8'h01);
    ec_host_model_inst.wr_reg(OFF_POWER_MONITOR_IRQ_MASK, 8'h04);
    wait_clk(2);
    chk("pmu vdc masked", {7'h00, o_irq}, 8'h00);
    i_pmu_pend = 2'b10;
    wait_clk(2);
    chk("pmu adapter open", {7'h00, o_irq_sum.pmu_sum}, 8'h01);
    i_pmu_pend = '0;
    for (int i = 0; i < 4; i++) begin
      i_pwrsrc_pend = 4'(1 << i);
      ec_host_model_inst.wr_reg(OFF_POWER_SOURCE_IRQ_MASK, 8'h78 & ~(8'h08 << i));
      wait_clk(2);
      chk("src open", {7'h00, o_irq_sum.pwrsrc_sum}, 8'h01);
      ec_host_model_inst.wr_reg(OFF_POWER_SOURCE_IRQ_MASK, 8'h08 << i);
      wait_clk(2);
      chk("src masked", {7'h00, o_irq_sum.pwrsrc_sum}, 8'h00);
    end
    i_pwrsrc_pend = '0;
  endtask : t_pending

  task automatic t_heat_mask();
    logic [7:0] d;
    ec_host_model_inst.wr_rd_reg(OFF_RESET_CAUSE_TWO_MASK, 8'hff, d);
    chk("two mask back to back", d, 8'h02);
    i_cause = 3'b001;
    wait_clk(6);
    i_cause = '0;
    chk("heat masked", {7'h00, o_irq}, 8'h00);
    rd_chk(OFF_RESET_CAUSE_TWO, 8'h02);
    ec_host_model_inst.wr_reg(OFF_RESET_CAUSE_TWO_MASK, 8'h00);
    wait_clk(2);
    chk("heat unmasked", {7'h00, o_irq}, 8'h01);
    ec_host_model_inst.wr_reg(OFF_RESET_CAUSE_TWO, 8'h00);
    wait_clk(2);
    chk("heat cleared", {7'h00, o_irq}, 8'h00);
  endtask : t_heat_mask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    error_cnt++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    i_rst_n = 1'b0;
    i_cause = '0;
    i_pmu_pend = '0;
    i_pwrsrc_pend = '0;
    wait_clk(5);
    i_rst_n = 1'b1;
    t_reset_values();
    t_write_read();
    t_causes();
    t_pending();
    t_heat_mask();
    wrap_up();
  end
endmodule : reset_cause_irq_mask_regs_test
